// file: design/irt_queue.sv
/*
  word queue of the transmitter; rewind restores the read pointer to
  the first word written since the last clear so it can be sent again.
  assumes clear and rewind are not given together with push.
*/
module irt_queue (
  input wire logic clk,
  input wire logic reset_n,
  irt_fifo_if.queue q
);
  import irt_pkg::*;

  irt_word_t mem_r [0:31];
  logic [5:0] wr_r;
  logic [5:0] rd_r;
  logic [5:0] base_r;

  assign q.rdata = mem_r[rd_r[4:0]];
  assign q.level = wr_r - rd_r;
  assign q.empty = (wr_r == rd_r);
  // full counts from the base so a rewind never overruns unread words
  assign q.full = ((wr_r - base_r) == 6'h20);

  // -------------------------------------------------------------
  // storage and pointers
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (q.push && !q.full) begin
      mem_r[wr_r[4:0]] <= q.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || q.clear) begin
      wr_r <= 6'h00;
      rd_r <= 6'h00;
      base_r <= 6'h00;
    end else if (q.rewind) begin
      rd_r <= base_r;
    end else begin
      if (q.push && !q.full) begin
        wr_r <= wr_r + 6'h01;
      end
      if (q.pop && !q.empty) begin
        rd_r <= rd_r + 6'h01;
      end
    end
  end
endmodule : irt_queue

// file: design/irt_transmitter.sv
// Contract
// - apb registers, separate carrier clock gate
// - code queue of 32 sixteen-bit words
// - repeat automatically while key held
// - interrupt when command transmission completes; none is raised while repeat is enabled
// - pulse width, distance, manchester, any symbols
// - time mode emits levels without carrier
// - word msb selects bit or segment
// - msb set means bit-sequence word
// - bits 14:11 count minus one, 0..10
// - bits 10:0 payload, expanded by timing
// - segment: bit14 mark, 13:0 duration
// - second repeat queue for repeat words
// - decoder pops queue, feeds modulator
// - repeat timer starts while key held
// - carrier generated from gated clock
// - modulator gate passes or blocks carrier
// - optional output inversion
// - carrier high and low time counts
// - one and zero mark/space durations
// - per-bit format: mark first or space
// - wait repeat interval between retransmissions
//
// Chosen here: the register offsets and register access over APB.
/*
  infrared code transmitter with apb slave, two word queues, decoder,
  modulator, carrier generator and output stage. assumes the carrier
  clock is the apb clock; a gate bit stands in for its clock enable.
*/
`include "irt_regs.svh"

module irt_transmitter
  import irt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key_held,
  output logic ir_out,
  output logic irq
);

  // -------------------------------------------------------------
  // registers and queues
  // -------------------------------------------------------------
  logic [8:0] ctrl_r;
  logic [31:0] carrier_on_off_time_r;
  logic [31:0] one_timing_r;
  logic [31:0] zero_timing_r;
  logic [15:0] retransmit_interval_r;
  logic done_r;
  logic busy_r;
  irt_state_t state_r;
  logic use_rpt_r;
  irt_fifo_if code_q ();
  irt_fifo_if rpt_q ();

  irt_queue u_code (
    .clk(clk),
    .reset_n(reset_n),
    .q(code_q)
  );
  irt_queue u_rpt (
    .clk(clk),
    .reset_n(reset_n),
    .q(rpt_q)
  );

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire transmit_trigger = wr && (paddr == `IRT_OFS_CTRL) && pwdata[`IRT_CTRL_START];
  wire one_bit_mark_first = ctrl_r[`IRT_CTRL_ONE_MARK];
  wire zero_bit_mark_first = ctrl_r[`IRT_CTRL_ZERO_MARK];
  wire carrier_clock_gate_enable = ctrl_r[`IRT_CTRL_CLK_GATE];
  wire known = (paddr[1:0] == 2'b00) && (paddr <= `IRT_OFS_STATUS);
  logic fin;

  // -------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped address
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
    end
  end

  // read data registered in the setup cycle, valid in the access phase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `IRT_OFS_CTRL: prdata <= {23'h000000, ctrl_r};
        `IRT_OFS_CARRIER: prdata <= carrier_on_off_time_r;
        `IRT_OFS_ONE_TIME: prdata <= one_timing_r;
        `IRT_OFS_ZERO_TIME: prdata <= zero_timing_r;
        `IRT_OFS_REPEAT: prdata <= {16'h0000, retransmit_interval_r};
        `IRT_OFS_STATUS: prdata <= {17'h00000, rpt_q.level, code_q.level,
                                    code_q.full, busy_r, done_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration writes; start, flush and irq_clr do not stick
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_r <= `IRT_CTRL_RST;
      carrier_on_off_time_r <= `IRT_CARRIER_RST;
      one_timing_r <= `IRT_TIME_RST;
      zero_timing_r <= `IRT_TIME_RST;
      retransmit_interval_r <= `IRT_REPEAT_RST;
    end else if (wr) begin
      case (paddr)
        `IRT_OFS_CTRL: ctrl_r <= {2'b00, pwdata[6:1], 1'b0};
        `IRT_OFS_CARRIER: carrier_on_off_time_r <= pwdata;
        `IRT_OFS_ONE_TIME: one_timing_r <= pwdata;
        `IRT_OFS_ZERO_TIME: zero_timing_r <= pwdata;
        `IRT_OFS_REPEAT: retransmit_interval_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // queue writes; the queue itself drops words while full
  wire flush = wr && (paddr == `IRT_OFS_CTRL) && pwdata[`IRT_CTRL_FLUSH];
  assign code_q.push = wr && (paddr == `IRT_OFS_CODE);
  assign rpt_q.push = wr && (paddr == `IRT_OFS_RPT_CODE);
  assign code_q.wdata = pwdata[15:0];
  assign rpt_q.wdata = pwdata[15:0];
  assign code_q.clear = flush;
  assign rpt_q.clear = flush;

  // -------------------------------------------------------------
  // completion flag: set wins over clear
  // -------------------------------------------------------------
  wire irq_clr = wr && (paddr == `IRT_OFS_CTRL) && pwdata[`IRT_CTRL_IRQ_CLR];
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_r <= 1'b0;
      irq <= 1'b0;
    end else begin
      done_r <= fin || (done_r && !irq_clr);
      irq <= fin || (done_r && !irq_clr);
    end
  end

  // -------------------------------------------------------------
  // carrier generator: high count then low count per period
  // -------------------------------------------------------------
  logic [15:0] car_cnt_r;
  logic car_r;
  // toggling at one, not zero, makes each phase last exactly its count
  always_ff @(posedge clk) begin
    if (!reset_n || !carrier_clock_gate_enable) begin
      car_cnt_r <= 16'h0000;
      car_r <= 1'b0;
    end else if (car_cnt_r <= 16'h0001) begin
      car_r <= !car_r;
      car_cnt_r <= car_r ? carrier_on_off_time_r[31:16] : carrier_on_off_time_r[15:0];
    end else begin
      car_cnt_r <= car_cnt_r - 16'h0001;
    end
  end

  // -------------------------------------------------------------
  // decoder and modulator
  // -------------------------------------------------------------
  irt_word_t word_r;
  logic [3:0] bit_idx_r;
  logic [15:0] dur_r;
  logic gate_r;
  logic [15:0] gap_r;
  // the active source: repeat queue when loaded and retransmitting
  wire src_empty = use_rpt_r ? rpt_q.empty : code_q.empty;
  wire irt_word_t src_word = use_rpt_r ? rpt_q.rdata : code_q.rdata;
  // a word is taken on the very edge the previous symbol ends, so no
  // fetch cycle stretches the symbol before it
  wire take = (state_r == IRT_FETCH) ||
              ((state_r == IRT_SEG) && (dur_r <= 16'h0001)) ||
              ((state_r == IRT_BIT2) && (bit_idx_r == 4'h0) && (dur_r <= 16'h0001));
  wire pop_now = take && !src_empty;
  assign code_q.pop = pop_now && !use_rpt_r;
  assign rpt_q.pop = pop_now && use_rpt_r;
  wire rewind = (state_r == IRT_GAP) && (gap_r == 16'h0000) && key_held;
  assign code_q.rewind = rewind && !use_rpt_r && (rpt_q.level == 6'h00);
  assign rpt_q.rewind = rewind && (use_rpt_r || rpt_q.level != 6'h00);
  wire cur_bit = word_r[bit_idx_r];
  // first half level of a bit follows its format bit
  wire first_mark = cur_bit ? one_bit_mark_first : zero_bit_mark_first;
  wire [31:0] bit_time = cur_bit ? one_timing_r : zero_timing_r;
  wire [15:0] mark_len = bit_time[15:0];
  wire [15:0] space_len = bit_time[31:16];
  wire [15:0] half2 = first_mark ? space_len : mark_len;
  // first half of the next bit: msb of a fresh word, or the next lower bit
  wire [3:0] src_len = (src_word[14:11] > `IRT_W_MAX_LEN) ? `IRT_W_MAX_LEN
                                                         : src_word[14:11];
  wire [3:0] nxt_idx = take ? src_len : (bit_idx_r - 4'h1);
  wire irt_word_t nxt_word = take ? src_word : word_r;
  wire nxt_bit = nxt_word[nxt_idx];
  wire nxt_mark = nxt_bit ? one_bit_mark_first : zero_bit_mark_first;
  wire [31:0] nxt_time = nxt_bit ? one_timing_r : zero_timing_r;
  wire [15:0] nxt_half1 = nxt_mark ? nxt_time[15:0] : nxt_time[31:16];
  assign fin = take && src_empty && busy_r && !ctrl_r[`IRT_CTRL_REPEAT_EN];

  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      state_r <= IRT_IDLE;
      busy_r <= 1'b0;
      use_rpt_r <= 1'b0;
      gate_r <= 1'b0;
      dur_r <= 16'h0000;
      gap_r <= 16'h0000;
      bit_idx_r <= 4'h0;
      word_r <= 16'h0000;
    end else begin
      case (state_r)
        IRT_IDLE: begin
          gate_r <= 1'b0;
          use_rpt_r <= 1'b0;
          if (transmit_trigger) begin
            state_r <= IRT_FETCH;
            busy_r <= 1'b1;
          end
        end
        IRT_FETCH: begin
          // word handling sits below the case
        end
        IRT_SEG: begin
          if (dur_r > 16'h0001) begin
            dur_r <= dur_r - 16'h0001;
          end
        end
        IRT_BIT1: begin
          if (dur_r <= 16'h0001) begin
            gate_r <= !first_mark;
            dur_r <= half2;
            state_r <= IRT_BIT2;
          end else begin
            dur_r <= dur_r - 16'h0001;
          end
        end
        IRT_BIT2: begin
          if (dur_r > 16'h0001) begin
            dur_r <= dur_r - 16'h0001;
          end else if (bit_idx_r != 4'h0) begin
            gate_r <= nxt_mark;
            dur_r <= nxt_half1;
            bit_idx_r <= nxt_idx;
            state_r <= IRT_BIT1;
          end
        end
        IRT_GAP: begin
          if (gap_r != 16'h0000) begin
            gap_r <= gap_r - 16'h0001;
          end else if (key_held) begin
            // repeat words take over when software loaded any
            use_rpt_r <= use_rpt_r || (rpt_q.level != 6'h00);
            state_r <= IRT_FETCH;
          end else begin
            busy_r <= 1'b0;
            state_r <= IRT_IDLE;
          end
        end
        default: state_r <= IRT_IDLE;
      endcase
      // next word, decoded on the edge the last symbol ends
      if (take) begin
        if (!src_empty) begin
          word_r <= src_word;
          if (src_word[`IRT_W_TYPE]) begin
            // lengths above ten are clamped to the legal top
            bit_idx_r <= src_len;
            gate_r <= nxt_mark;
            dur_r <= nxt_half1;
            state_r <= IRT_BIT1;
          end else begin
            gate_r <= src_word[`IRT_W_MARK];
            dur_r <= {2'b00, src_word[13:0]};
            state_r <= IRT_SEG;
          end
        end else if (ctrl_r[`IRT_CTRL_REPEAT_EN] && key_held) begin
          gate_r <= 1'b0;
          gap_r <= retransmit_interval_r;
          state_r <= IRT_GAP;
        end else begin
          gate_r <= 1'b0;
          busy_r <= 1'b0;
          state_r <= IRT_IDLE;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // output stage: carrier gating, time mode and inversion
  // -------------------------------------------------------------
  wire modulated = gate_r && (ctrl_r[`IRT_CTRL_TIME_MODE] || car_r);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ir_out <= 1'b0;
    end else begin
      ir_out <= modulated ^ ctrl_r[`IRT_CTRL_INVERT];
    end
  end

endmodule : irt_transmitter

// file: shared/irt_fifo_if.sv
/*
  push/pop channel between transmitter core and its word queues.
  assumes a single clock domain.
*/
interface irt_fifo_if;
  logic push;
  logic pop;
  logic clear;
  logic rewind;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic empty;
  logic full;
  logic [5:0] level;
  modport owner (output push, pop, clear, rewind, wdata, input rdata, empty, full, level);
  modport queue (input push, pop, clear, rewind, wdata, output rdata, empty, full, level);
endinterface : irt_fifo_if

// file: shared/irt_pkg.sv
/*
  types of the infrared code transmitter.
  assumes nothing beyond a sv compiler.
*/
package irt_pkg;
  // engine states
  typedef enum logic [2:0] {
    IRT_IDLE,
    IRT_FETCH,
    IRT_SEG,
    IRT_BIT1,
    IRT_BIT2,
    IRT_GAP
  } irt_state_t;
  typedef logic [15:0] irt_word_t;
endpackage : irt_pkg

// file: shared/irt_regs.svh
/*
  register offsets, field positions, reset values and word sizes
  of the infrared code transmitter. assumes apb with word-aligned offsets.
*/
`ifndef IRT_REGS_SVH
`define IRT_REGS_SVH

// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define IRT_OFS_CTRL 12'h000
`define IRT_OFS_CARRIER 12'h004
`define IRT_OFS_ONE_TIME 12'h008
`define IRT_OFS_ZERO_TIME 12'h00C
`define IRT_OFS_REPEAT 12'h010
`define IRT_OFS_CODE 12'h014
`define IRT_OFS_RPT_CODE 12'h018
`define IRT_OFS_STATUS 12'h01C

// -------------------------------------------------------------
// control fields
// -------------------------------------------------------------
`define IRT_CTRL_START 0
`define IRT_CTRL_ONE_MARK 1
`define IRT_CTRL_ZERO_MARK 2
`define IRT_CTRL_INVERT 3
`define IRT_CTRL_REPEAT_EN 4
`define IRT_CTRL_TIME_MODE 5
`define IRT_CTRL_CLK_GATE 6
`define IRT_CTRL_FLUSH 7
`define IRT_CTRL_IRQ_CLR 8

// -------------------------------------------------------------
// word encoding and sizes
// -------------------------------------------------------------
`define IRT_W_TYPE 15
`define IRT_W_MARK 14
`define IRT_W_LEN_HI 14
`define IRT_W_LEN_LO 11
`define IRT_W_MAX_LEN 4'hA
`define IRT_DEPTH 32
`define IRT_RPT_DEPTH 32

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define IRT_CARRIER_RST 32'h0000_0000
`define IRT_TIME_RST 32'h0000_0000
`define IRT_REPEAT_RST 16'h0000
`define IRT_CTRL_RST 9'h000

`endif

// file: tb/irt_ir_rx.sv
/* receiver facing the emitter: records the length of each lit stretch.
   assumes the emitter line is sampled on the block clock. */
module irt_ir_rx (
  input wire logic clk,
  input wire logic ir_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int widths[$];
  int run = 0;
  // ----
  // run measurement
  // ----
  // a stretch is logged only when light goes dark, so a lit tail is not seen
  always @(posedge clk) begin
    if (ir_in === 1'b1) begin
      run++;
    end else if (run > 0) begin
      widths.push_back(run);
      run = 0;
    end
  end
endmodule : irt_ir_rx

// file: tb/irt_transmitter_sva.sv
/* port checker of the infrared transmitter.
   assumes it is bound to irt_transmitter, one clock domain. */
module irt_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic key_held,
  input wire logic ir_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // helpers
  // ----
  logic clr_w;
  // irq clear seen in an access phase
  assign clr_w = psel && penable && pwrite && paddr == 12'h000 && pwdata[8];
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_good;
    s_setup ##0 (paddr <= 12'h01C && paddr[1:0] == 2'b00);
  endsequence
  sequence s_bad;
    s_setup ##0 (paddr > 12'h01C || paddr[1:0] != 2'b00);
  endsequence
  // ----
  // assertions
  // ----
  a_ready_next: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_bad: assert property (s_bad |=> pready && pslverr)
    else $error("bad address not refused");
  a_err_good: assert property (s_good |=> !pslverr)
    else $error("good address refused");
  // flag may lag the clear by one register stage
  a_irq_hold: assert property (irq && !clr_w && !$past(clr_w) |=> irq)
    else $error("irq dropped without clear");
  a_irq_clear: assert property (clr_w && pready |=> ##1 !irq)
    else $error("irq not cleared");
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !ir_out && !irq && !pready)
    else $error("outputs active in reset");
endmodule : irt_chk

bind irt_transmitter irt_chk chk_u (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .key_held(key_held), .ir_out(ir_out), .irq(irq));

// file: tb/tb.sv
/* self-checking bench of the infrared transmitter.
   assumes irt_transmitter, its bound checker and the receiver model. */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, psel, penable, pwrite, key_held, pready, pslverr, ir_out, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [15:0] w;
  int fails, checked, seed, n, l;
  // gate, time mode, both bit kinds mark first
  localparam logic [31:0] t_mode = 32'h0000_0066;
  irt_transmitter dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .key_held(key_held), .ir_out(ir_out), .irq(irq));
  irt_ir_rx rx_u (.clk(clk), .ir_in(ir_out));
  always #2.5 clk = ~clk;
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // request held until ready is sampled; one idle cycle between transfers
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dv,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dv;
    @(posedge clk);
    penable <= 1'b1;
    // ready and its data are looked at mid-cycle, where they have settled,
    // and the request still stands at the edge that completes it
    do begin
      @(negedge clk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (k == 64) fails++;
    r = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic push(input logic [15:0] v);
    apb(1'b1, 12'h014, {16'h0000, v}, rd, err);
  endtask : push
  task automatic go(input logic [31:0] c);
    int k;
    k = 0;
    rx_u.widths.delete();
    apb(1'b1, 12'h000, c | 32'h141, rd, err);
    while (irq !== 1'b1 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    chk(irq, 1'b1);
    apb(1'b1, 12'h000, c | 32'h140, rd, err);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask : go
  // one mark lasts 3 cycles, zero mark 1
  function automatic logic [31:0] exp_mark(input logic [15:0] wd, input int i);
    return wd[i] ? 32'h3 : 32'h1;
  endfunction : exp_mark
  task automatic test_done;
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // ----
  // scenarios
  // ----
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    key_held = 1'b0;
    seed = 32'h4AAADB74;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0, rd, err);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h006, 32'h0, rd, err);
    chk(err, 1'b1);
    apb(1'b1, 12'h020, 32'h0, rd, err);
    chk(err, 1'b1);
    for (int i = 1; i < 5; i++) begin
      d = $random(seed);
      apb(1'b1, 12'(i * 4), d, rd, err);
      apb(1'b0, 12'(i * 4), 32'h0, rd, err);
      chk(rd, i == 4 ? d & 32'h0000FFFF : d);
    end
    apb(1'b1, 12'h004, 32'h0003_0002, rd, err);
    apb(1'b1, 12'h008, 32'h0002_0003, rd, err);
    apb(1'b1, 12'h00C, 32'h0004_0001, rd, err);
    apb(1'b1, 12'h010, 32'h0000_0010, rd, err);
    // one word past full must be dropped
    repeat (33) push(16'($random(seed)));
    apb(1'b0, 12'h01C, 32'h0, rd, err);
    chk(rd & 32'h1FC, 32'h104);
    apb(1'b1, 12'h000, 32'h80, rd, err);
    apb(1'b0, 12'h01C, 32'h0, rd, err);
    chk(rd & 32'h1FC, 32'h0);
    // painted marks split by spaces
    d = 32'h1 + ($random(seed) & 32'hF);
    push(16'h4000 | d[15:0]);
    push(16'h0003);
    push(16'h4009);
    push(16'h0002);
    go(t_mode);
    chk(rx_u.widths.size(), 2);
    chk(rx_u.widths[0], d);
    chk(rx_u.widths[1], 9);
    // digital words: longest, shortest, then random lengths; formats alternate
    for (int k = 0; k < 4; k++) begin
      l = k == 0 ? 10 : k == 1 ? 0 : {$random(seed)} % 11;
      w = {1'b1, 4'(l), 11'($random(seed))};
      push(w);
      push(16'h0002);
      go(k % 2 ? 32'h60 : t_mode);
      chk(rx_u.widths.size(), l + 1);
      for (int i = l; i >= 0; i--) chk(rx_u.widths[l - i], exp_mark(w, i));
    end
    apb(1'b1, 12'h000, t_mode | 32'h8, rd, err);
    repeat (3) @(posedge clk);
    chk(ir_out, 1'b1);
    apb(1'b1, 12'h000, t_mode, rd, err);
    repeat (3) @(posedge clk);
    chk(ir_out, 1'b0);
    // long mark chopped by a 2 high, 3 low carrier
    push(16'h4014);
    push(16'h0004);
    go(32'h46);
    chk(rx_u.widths.size() > 2, 1'b1);
    chk(rx_u.widths[1], 2);
    // key held: code words once, then the repeat queue each time
    key_held <= 1'b1;
    push(16'h4004);
    push(16'h0002);
    apb(1'b1, 12'h018, 32'h4007, rd, err);
    apb(1'b1, 12'h018, 32'h0002, rd, err);
    rx_u.widths.delete();
    apb(1'b1, 12'h000, t_mode | 32'h151, rd, err);
    n = 0;
    while (rx_u.widths.size() < 3 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    key_held <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, 12'h01C, 32'h0, rd, err);
      n++;
    end while (rd[1] !== 1'b0 && n < 500);
    chk(rd[1], 1'b0);
    chk(rx_u.widths[0], 4);
    chk(rx_u.widths[1], 7);
    chk(rx_u.widths[2], 7);
    chk(irq, 1'b0);
    test_done();
  end
  // hang guard, well past the longest expected run
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule : tb
